// file: logic/ddr2mr_pkg.sv
// constants, types and field layout of the mode-register and driver-calibration block
// Summary of operation
// - mode set command with both bank bits low loads A0..A12 into base mode register
// - burst length comes from A[2:0]; only lengths 4 and 8 are supported
// - A3 selects sequential or interleaved order; A[6:4] sets read latency
// - read latency is whole clocks only; no half-cycle option exists
// - A8 high in base mode register resets the delay-locked loop
// - A[11:9] holds write-recovery cycles, tWR over clock period rounded up
// - bank bits 01 load extended register one; it must be programmed at start
// - register one A0 disables the loop, A1 selects reduced driver strength
// - register one A[5:3] additive latency, A[9:7] calibration code, A10 strobe-bar off
// - register one bits A2 and A6 select nominal termination
// - loop turns off in self refresh, re-enables and resets on exit
// - register two A7 enables extended self-refresh rate for hot case temperature
// - code 000 exit, 001 drive high, 010 drive low, 100 adjust, 111 default
// - drive high puts data and strobe high, strobe-bar low; drive low the opposite
// - four-bit burst code, first bit first, raises or lowers pull-up and pull-down
// - sixteen steps, saturating at both ends; reset step may be any step
// - each adjustment applies to all data and strobe drivers together
// - calibration applies only at full strength; default unused at reduced strength
package ddr2mr_pkg;
    localparam int unsigned ADDR_W = 13;
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic [1:0] BA_EMR2 = 2'h2;
    localparam int unsigned MR_BL_LSB = 0;
    localparam int unsigned MR_BT_BIT = 3;
    localparam int unsigned MR_CL_LSB = 4;
    localparam int unsigned MR_DLLRST_BIT = 8;
    localparam int unsigned MR_WR_LSB = 9;
    localparam int unsigned E1_DLLDIS_BIT = 0;
    localparam int unsigned E1_RDS_BIT = 1;
    localparam int unsigned E1_RTT0_BIT = 2;
    localparam int unsigned E1_AL_LSB = 3;
    localparam int unsigned E1_RTT1_BIT = 6;
    localparam int unsigned E1_OCD_LSB = 7;
    localparam int unsigned E1_DQSN_DIS_BIT = 10;
    localparam int unsigned E1_READ_STROBE_BIT = 11;
    localparam int unsigned E2_SRT_BIT = 7;
    localparam logic [2:0] BL_CODE4 = 3'h2;
    localparam logic [2:0] BL_CODE8 = 3'h3;
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] OCD_DRV1 = 3'h1;
    localparam logic [2:0] OCD_DRV0 = 3'h2;
    localparam logic [2:0] OCD_ADJ = 3'h4;
    localparam logic [2:0] OCD_DEF = 3'h7;
    localparam int unsigned CODE_BEATS = 4;
    localparam int unsigned STEP_COUNT = 16;
    localparam logic [3:0] STEP_DEF = 4'h8;
    localparam int unsigned DLL_LOCK_CYC = 200;
    localparam logic [12:0] REG_RST = 13'h0000;

    typedef enum logic [3:0] {
        CMD_MRS = 4'b0001,
        CMD_SRE = 4'b0010,
        CMD_WR = 4'b0100,
        CMD_OTHER = 4'b1000
    } ddr2mr_cmd_e;

    typedef enum logic [3:0] {
        OCD_IDLE = 4'b0001,
        OCD_HIGH = 4'b0010,
        OCD_LOW = 4'b0100,
        OCD_ADJUST = 4'b1000
    } ddr2mr_ocd_e;

    typedef struct packed {
        logic bl8;
        logic bl_err;
        logic ileave;
        logic [2:0] cas_lat;
        logic [2:0] wr_cyc;
    } ddr2mr_mode_s;

    typedef struct packed {
        logic dll_dis;
        logic reduced;
        logic [1:0] rtt;
        logic [2:0] add_lat;
        logic dqsn_dis;
        logic read_strobe_option;
        logic srt_ext;
    } ddr2mr_ext_s;
endpackage

// file: logic/ddr2mr_step.sv
// saturating driver strength step counter
`timescale 1ns/100ps
`default_nettype none
module ddr2mr_step #(
    parameter int unsigned STEPS = ddr2mr_pkg::STEP_COUNT,
    parameter logic [3:0] DEF = ddr2mr_pkg::STEP_DEF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // control
    input wire logic i_load_def,
    input wire logic i_inc,
    input wire logic i_dec,
    // strength
    output logic [3:0] o_step
);
    // the counter is four bits wide, so only a sixteen-step range fits
    if (STEPS != 16) begin : g_bad_range
        $error("ddr2mr_step: unsupported step range");
    end

    // the ends are sticky so a burst of increments cannot wrap round
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_step <= DEF;
        end else if (i_ce) begin
            if (i_load_def) begin
                o_step <= DEF;
            end else if (i_inc && o_step != 4'hf) begin
                o_step <= o_step + 4'h1;
            end else if (i_dec && o_step != 4'h0) begin
                o_step <= o_step - 4'h1;
            end
        end
    end

    chk_step_saturate: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_load_def && o_step == 4'hf && i_inc) |=> o_step == 4'hf)
        else $error("step wrapped above top");
endmodule // ddr2mr_step
`default_nettype wire

// file: logic/ddr2mr_core.sv
// mode registers, loop control and output driver calibration
`timescale 1ns/100ps
`default_nettype none
module ddr2mr_core #(
    parameter int unsigned DQ_W = 16,
    parameter int unsigned DLL_CYC = ddr2mr_pkg::DLL_LOCK_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // command pins
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [1:0] i_ba,
    input wire logic [12:0] i_addr,
    // write data beats
    input wire logic i_beat_vld,
    input wire logic [DQ_W-1:0] i_beat_dq,
    // decoded settings
    output ddr2mr_pkg::ddr2mr_mode_s o_mode,
    output ddr2mr_pkg::ddr2mr_ext_s o_ext,
    // loop control
    output logic o_dll_en,
    output logic o_dll_rst,
    output logic o_dll_locked,
    output logic o_self_ref,
    // output drivers
    output logic o_drv_oe,
    output logic [DQ_W-1:0] o_dq_out,
    output logic [1:0] o_dqs_out,
    output logic [1:0] o_dqs_n_out,
    output logic [3:0] o_pu_step,
    output logic [3:0] o_pd_step,
    output logic o_ocd_default
);
    // the lock counter is ten bits wide
    if (DQ_W < 1 || DLL_CYC < 1 || DLL_CYC > 1023) begin : g_bad_param
        $error("ddr2mr_core: unsupported parameter");
    end

    function automatic ddr2mr_pkg::ddr2mr_cmd_e cmd_of(input logic ras_n, input logic cas_n,
                                                      input logic we_n);
        if (!ras_n && !cas_n && !we_n) begin
            return ddr2mr_pkg::CMD_MRS;
        end else if (!ras_n && !cas_n && we_n) begin
            return ddr2mr_pkg::CMD_SRE;
        end else if (ras_n && !cas_n && !we_n) begin
            return ddr2mr_pkg::CMD_WR;
        end
        return ddr2mr_pkg::CMD_OTHER;
    endfunction

    // adjust code: bit 3 is first_code_bit_time; {pu_inc, pu_dec, pd_inc, pd_dec}
    function automatic logic [3:0] adj_of(input logic [3:0] code);
        unique case (code)
            4'h0: return 4'b0000;
            4'h1: return 4'b1000;
            4'h2: return 4'b0100;
            4'h4: return 4'b0010;
            4'h8: return 4'b0001;
            4'h5: return 4'b1010;
            4'h6: return 4'b0110;
            4'h9: return 4'b1001;
            4'ha: return 4'b0101;
            default: return 4'b0000;
        endcase
    endfunction

    logic cke_prev_r;
    logic sel;
    logic mrs_go;
    logic sre_go;
    logic srx_go;
    logic emr1_go;
    logic [2:0] ocd_code;
    logic adj_go;
    logic [3:0] adj_act;
    logic [1:0] code_cnt_r;
    logic [3:0] code_r;
    logic [9:0] lock_cnt_r;
    logic [1:0] inc_v;
    logic [1:0] dec_v;
    logic [3:0] step_v [2];
    ddr2mr_pkg::ddr2mr_ocd_e ocd_r;
    ddr2mr_pkg::ddr2mr_ocd_e ocd_nxt;

    // commands count only with clock enable high and chip select low
    assign sel = i_ce && i_cke && cke_prev_r && !i_cs_n;
    assign mrs_go = sel && cmd_of(i_ras_n, i_cas_n, i_we_n) == ddr2mr_pkg::CMD_MRS;
    // self refresh entry registers on the edge where clock enable falls
    assign sre_go = i_ce && cke_prev_r && !i_cke && !i_cs_n && !o_self_ref &&
                    cmd_of(i_ras_n, i_cas_n, i_we_n) == ddr2mr_pkg::CMD_SRE;
    assign srx_go = i_ce && o_self_ref && i_cke;
    assign emr1_go = mrs_go && i_ba == ddr2mr_pkg::BA_EMR1;
    assign ocd_code = i_addr[ddr2mr_pkg::E1_OCD_LSB +: 3];
    assign adj_go = i_ce && ocd_r == ddr2mr_pkg::OCD_ADJUST && i_beat_vld && code_cnt_r == 2'h3;
    // reduced strength blocks adjustment: calibration is only for full drive
    assign adj_act = (adj_go && !o_ext.reduced) ? adj_of({code_r[2:0], i_beat_dq[0]})
                                                : 4'b0000;
    assign inc_v = {adj_act[1], adj_act[3]};
    assign dec_v = {adj_act[0], adj_act[2]};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cke_prev_r <= 1'b0;
        end else if (i_ce) begin
            cke_prev_r <= i_cke;
        end
    end

    // base mode register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mode <= '0;
        end else if (mrs_go && i_ba == ddr2mr_pkg::BA_MR) begin
            o_mode.bl8 <= i_addr[ddr2mr_pkg::MR_BL_LSB +: 3] == ddr2mr_pkg::BL_CODE8;
            o_mode.bl_err <= i_addr[ddr2mr_pkg::MR_BL_LSB +: 3] != ddr2mr_pkg::BL_CODE8 &&
                             i_addr[ddr2mr_pkg::MR_BL_LSB +: 3] != ddr2mr_pkg::BL_CODE4;
            o_mode.ileave <= i_addr[ddr2mr_pkg::MR_BT_BIT];
            // latency is held as a plain count of clocks, no half-cycle field
            o_mode.cas_lat <= i_addr[ddr2mr_pkg::MR_CL_LSB +: 3];
            o_mode.wr_cyc <= i_addr[ddr2mr_pkg::MR_WR_LSB +: 3];
        end
    end

    // extended registers one and two; register three has nothing to hold
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ext <= '0;
        end else if (emr1_go) begin
            o_ext.dll_dis <= i_addr[ddr2mr_pkg::E1_DLLDIS_BIT];
            o_ext.reduced <= i_addr[ddr2mr_pkg::E1_RDS_BIT];
            o_ext.rtt <= {i_addr[ddr2mr_pkg::E1_RTT1_BIT], i_addr[ddr2mr_pkg::E1_RTT0_BIT]};
            o_ext.add_lat <= i_addr[ddr2mr_pkg::E1_AL_LSB +: 3];
            o_ext.dqsn_dis <= i_addr[ddr2mr_pkg::E1_DQSN_DIS_BIT];
            o_ext.read_strobe_option <= i_addr[ddr2mr_pkg::E1_READ_STROBE_BIT];
        end else if (mrs_go && i_ba == ddr2mr_pkg::BA_EMR2) begin
            o_ext.srt_ext <= i_addr[ddr2mr_pkg::E2_SRT_BIT];
        end
    end

    // self refresh tracking
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_self_ref <= 1'b0;
        end else if (sre_go) begin
            o_self_ref <= 1'b1;
        end else if (srx_go) begin
            o_self_ref <= 1'b0;
        end
    end

    // loop enable follows register one but is forced off in self refresh
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dll_en <= 1'b0;
        end else if (sre_go) begin
            o_dll_en <= 1'b0;
        end else if (srx_go) begin
            o_dll_en <= !o_ext.dll_dis;
        end else if (emr1_go) begin
            o_dll_en <= !i_addr[ddr2mr_pkg::E1_DLLDIS_BIT];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dll_rst <= 1'b0;
        end else if (i_ce) begin
            o_dll_rst <= (mrs_go && i_ba == ddr2mr_pkg::BA_MR && i_addr[ddr2mr_pkg::MR_DLLRST_BIT]) ||
                         (srx_go && !o_ext.dll_dis);
        end
    end

    // lock flag only reports the settle time; reads are not blocked here
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lock_cnt_r <= '0;
        end else if (i_ce) begin
            if (o_dll_rst || !o_dll_en) begin
                lock_cnt_r <= '0;
            end else if (lock_cnt_r != DLL_CYC[9:0]) begin
                lock_cnt_r <= lock_cnt_r + 10'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dll_locked <= 1'b0;
        end else if (i_ce) begin
            o_dll_locked <= o_dll_en && !o_dll_rst && lock_cnt_r == DLL_CYC[9:0] - 10'h1 ||
                            o_dll_locked && o_dll_en && !o_dll_rst;
        end
    end

    // calibration state
    always_comb begin
        ocd_nxt = ocd_r;
        if (emr1_go) begin
            unique case (ocd_code)
                ddr2mr_pkg::OCD_EXIT: ocd_nxt = ddr2mr_pkg::OCD_IDLE;
                ddr2mr_pkg::OCD_DRV1: ocd_nxt = ddr2mr_pkg::OCD_HIGH;
                ddr2mr_pkg::OCD_DRV0: ocd_nxt = ddr2mr_pkg::OCD_LOW;
                ddr2mr_pkg::OCD_ADJ: ocd_nxt = ddr2mr_pkg::OCD_ADJUST;
                ddr2mr_pkg::OCD_DEF: ocd_nxt = ddr2mr_pkg::OCD_IDLE;
                default: ocd_nxt = ocd_r;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ocd_r <= ddr2mr_pkg::OCD_IDLE;
        end else if (i_ce) begin
            ocd_r <= ocd_nxt;
        end
    end

    // burst code collection, first beat lands in the top bit
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            code_cnt_r <= 2'h0;
            code_r <= 4'h0;
        end else if (i_ce) begin
            if (ocd_r != ddr2mr_pkg::OCD_ADJUST) begin
                code_cnt_r <= 2'h0;
            end else if (i_beat_vld) begin
                code_cnt_r <= code_cnt_r + 2'h1;
                code_r <= {code_r[2:0], i_beat_dq[0]};
            end
        end
    end

    // drive test outputs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_drv_oe <= 1'b0;
            o_dq_out <= '0;
            o_dqs_out <= 2'h0;
            o_dqs_n_out <= 2'h0;
        end else if (i_ce) begin
            o_drv_oe <= ocd_nxt == ddr2mr_pkg::OCD_HIGH || ocd_nxt == ddr2mr_pkg::OCD_LOW;
            o_dq_out <= {DQ_W{ocd_nxt == ddr2mr_pkg::OCD_HIGH}};
            o_dqs_out <= {2{ocd_nxt == ddr2mr_pkg::OCD_HIGH}};
            o_dqs_n_out <= {2{ocd_nxt == ddr2mr_pkg::OCD_LOW}};
        end
    end

    // default characteristics only meaningful at full strength
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ocd_default <= 1'b0;
        end else if (i_ce) begin
            if (emr1_go && ocd_code == ddr2mr_pkg::OCD_DEF) begin
                o_ocd_default <= !i_addr[ddr2mr_pkg::E1_RDS_BIT];
            end else if (emr1_go && i_addr[ddr2mr_pkg::E1_RDS_BIT]) begin
                o_ocd_default <= 1'b0;
            end else if (|adj_act) begin
                o_ocd_default <= 1'b0;
            end
        end
    end

    // one shared setting per direction drives every data and strobe pin
    for (genvar g = 0; g < 2; g++) begin : g_drv
        ddr2mr_step #(
            .STEPS(ddr2mr_pkg::STEP_COUNT),
            .DEF(ddr2mr_pkg::STEP_DEF)
        ) u_step (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_ce(i_ce),
            .i_load_def(emr1_go && ocd_code == ddr2mr_pkg::OCD_DEF),
            .i_inc(inc_v[g]),
            .i_dec(dec_v[g]),
            .o_step(step_v[g])
        );
    end
    assign o_pu_step = step_v[0];
    assign o_pd_step = step_v[1];

    sequence s_srx;
        o_self_ref && i_ce && i_cke;
    endsequence

    chk_sr_dll_off: assert property (@(posedge i_clk) disable iff (i_rst)
        sre_go |=> !o_dll_en && o_self_ref)
        else $error("loop still on in self refresh");
    chk_sr_exit_rst: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_srx ##0 !o_ext.dll_dis) |=> o_dll_rst && o_dll_en && !o_self_ref)
        else $error("loop not reset at self refresh exit");
    chk_mr_dll_rst: assert property (@(posedge i_clk) disable iff (i_rst)
        (mrs_go && i_ba == 2'h0 && i_addr[8]) |=> o_dll_rst)
        else $error("loop reset bit ignored");
    chk_mr_fields: assert property (@(posedge i_clk) disable iff (i_rst)
        (mrs_go && i_ba == 2'h0) |=> o_mode.cas_lat == $past(i_addr[6:4]) &&
        o_mode.ileave == $past(i_addr[3]) && o_mode.wr_cyc == $past(i_addr[11:9]))
        else $error("base mode fields not loaded");
    chk_bl_decode: assert property (@(posedge i_clk) disable iff (i_rst)
        (mrs_go && i_ba == 2'h0 && i_addr[2:0] == 3'h2) |=> !o_mode.bl8 && !o_mode.bl_err)
        else $error("burst four decoded wrong");
    chk_drive_high: assert property (@(posedge i_clk) disable iff (i_rst)
        (emr1_go && i_addr[9:7] == 3'h1) |=> o_drv_oe && &o_dq_out && &o_dqs_out && !(|o_dqs_n_out))
        else $error("drive high levels wrong");
    chk_drive_low: assert property (@(posedge i_clk) disable iff (i_rst)
        (emr1_go && i_addr[9:7] == 3'h2) |=> o_drv_oe && !(|o_dq_out) && &o_dqs_n_out)
        else $error("drive low levels wrong");
    chk_adj_pu_inc: assert property (@(posedge i_clk) disable iff (i_rst)
        (adj_go && !o_ext.reduced && {code_r[2:0], i_beat_dq[0]} == 4'h1 && o_pu_step != 4'hf)
        |=> o_pu_step == $past(o_pu_step) + 4'h1 && o_pd_step == $past(o_pd_step))
        else $error("pull-up increment missed");
    chk_adj_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
        (adj_go && {code_r[2:0], i_beat_dq[0]} == 4'h3) |=> $stable(o_pu_step) && $stable(o_pd_step))
        else $error("reserved code changed strength");
    chk_no_cs_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cs_n && !o_self_ref && i_ce) |=> $stable(o_mode) && $stable(o_ext))
        else $error("command taken without select");
endmodule // ddr2mr_core
`default_nettype wire

// file: test/ddr2mr_ctrl_model.sv
// controller-side model issuing mode commands, self refresh and adjust bursts
`timescale 1ns/100ps
`default_nettype none
module ddr2mr_ctrl_model #(
    parameter int unsigned DQ_W = 16
) (
    // clock
    input wire logic i_clk,
    // command pins
    output logic o_cke,
    output logic o_cs_n,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic [1:0] o_ba,
    output logic [12:0] o_addr,
    // adjust burst
    output logic o_beat_vld,
    output logic [DQ_W-1:0] o_beat_dq
);
    // this model never issues a read, so the loop lock wait cannot be broken
    initial begin
        {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h0f;
        {o_ba, o_addr, o_beat_vld, o_beat_dq} = '0;
    end
    // pins = {cs_n, ras_n, cas_n, we_n}; pins then return high and the address flips so a stale value never passes
    task automatic cmd(input logic cke, input logic [3:0] pins, input logic [1:0] ba, input logic [12:0] a);
        @(posedge i_clk);
        {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} <= {cke, pins};
        o_ba <= ba;
        o_addr <= a;
        @(posedge i_clk);
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'hf;
        o_addr <= ~a;
    endtask
    task automatic mrs(input logic [1:0] ba, input logic [12:0] a);
        logic [12:0] v;
        v = a;
        if (ba == 2'h0) v[7] = 1'b0;
        if (ba == 2'h2) v = v & 13'h0080;
        if (ba == 2'h3) v = 13'h0000;
        cmd(1'b1, 4'h0, ba, v);
        repeat (2) @(posedge i_clk);
    endtask
    task automatic sr_exit();
        @(posedge i_clk);
        o_cke <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask
    // same code on every data pin, first bit time first
    task automatic burst(input logic [3:0] code);
        for (int i = 3; i >= 0; i--) begin
            @(posedge i_clk);
            o_beat_vld <= 1'b1;
            o_beat_dq <= {DQ_W{code[i]}};
        end
        @(posedge i_clk);
        o_beat_vld <= 1'b0;
        o_beat_dq <= ~o_beat_dq;
    endtask
endmodule // ddr2mr_ctrl_model
`default_nettype wire

// file: test/ddr2_mode_register_ocd_tb.sv
// self-checking testbench of the mode-register and driver-calibration core
`timescale 1ns/100ps
`default_nettype none
module ddr2_mode_register_ocd_tb;
    localparam int unsigned DLL_CYC = 5; // shortened lock wait keeps the run short
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic ce = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, bv;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [15:0] bdq, o_dq_out;
    ddr2mr_pkg::ddr2mr_mode_s o_mode;
    ddr2mr_pkg::ddr2mr_ext_s o_ext;
    logic o_dll_en, o_dll_rst, o_dll_locked, o_self_ref, o_drv_oe, o_ocd_default;
    logic [1:0] o_dqs_out, o_dqs_n_out;
    logic [3:0] o_pu_step, o_pd_step;
    int bad_count = 0;
    int num_checks = 0;
    int pulses = 0;
    ddr2mr_ctrl_model #(.DQ_W(16)) u_ctrl (.i_clk, .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
        .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr), .o_beat_vld(bv), .o_beat_dq(bdq));
    ddr2mr_core #(.DQ_W(16), .DLL_CYC(DLL_CYC)) i_dut (.i_clk, .i_rst, .i_ce(ce), .i_cke(cke),
        .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr),
        .i_beat_vld(bv), .i_beat_dq(bdq), .o_mode, .o_ext, .o_dll_en, .o_dll_rst, .o_dll_locked,
        .o_self_ref, .o_drv_oe, .o_dq_out, .o_dqs_out, .o_dqs_n_out, .o_pu_step, .o_pd_step,
        .o_ocd_default);
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_dll_rst === 1'b1) pulses <= pulses + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [3:0] upd(input logic [3:0] s, input logic [1:0] op);
        if (op == 2'b01 && s != 4'hf) return s + 4'h1;
        if (op == 2'b10 && s != 4'h0) return s - 4'h1;
        return s;
    endfunction
    task automatic t_reset();
        #1;
        chk({o_mode, o_ext, o_dll_en, o_self_ref, o_drv_oe, o_ocd_default}, 0, "reset state");
        chk({o_pu_step, o_pd_step}, 8'h88, "reset steps");
    endtask
    task automatic t_mode();
        int p;
        u_ctrl.mrs(2'h1, 13'h0000);
        #1;
        chk(o_dll_en, 1, "loop enabled");
        p = pulses;
        u_ctrl.mrs(2'h0, 13'h075b);
        #1;
        chk(o_mode, {1'b1, 1'b0, 1'b1, 3'h5, 3'h3}, "mode fields");
        chk(pulses, p + 1, "loop reset pulse");
        chk(o_dll_locked, 0, "lock too early");
        for (int n = 0; n < 30 && o_dll_locked !== 1'b1; n++) @(posedge i_clk);
        #1;
        chk(o_dll_locked, 1, "lock reached");
        u_ctrl.mrs(2'h0, 13'h0042);
        #1;
        chk(o_mode, {1'b0, 1'b0, 1'b0, 3'h4, 3'h0}, "burst four");
        chk(pulses, p + 1, "no loop reset");
        u_ctrl.mrs(2'h0, 13'h0001);
        #1;
        chk(o_mode, {1'b0, 1'b1, 1'b0, 3'h0, 3'h0}, "bad burst code");
    endtask
    task automatic t_ext();
        u_ctrl.mrs(2'h1, 13'h0c2d);
        #1;
        chk(o_ext, {1'b1, 1'b0, 2'b01, 3'h5, 1'b1, 1'b1, 1'b0}, "ext one");
        chk(o_dll_en, 0, "loop disabled");
        u_ctrl.mrs(2'h2, 13'h0080);
        u_ctrl.mrs(2'h3, 13'h1fff);
        u_ctrl.cmd(1'b1, 4'h8, 2'h0, 13'h0002);
        #1;
        chk(o_ext, {1'b1, 1'b0, 2'b01, 3'h5, 1'b1, 1'b1, 1'b1}, "ext two");
        chk(o_mode, {1'b0, 1'b1, 1'b0, 3'h0, 3'h0}, "deselect ignored");
        @(posedge i_clk);
        ce <= 1'b0;
        u_ctrl.mrs(2'h0, 13'h0003);
        ce <= 1'b1;
        #1;
        chk(o_mode, {1'b0, 1'b1, 1'b0, 3'h0, 3'h0}, "frozen by enable");
    endtask
    task automatic t_selfref();
        int p;
        u_ctrl.mrs(2'h1, 13'h0000);
        u_ctrl.cmd(1'b0, 4'h1, 2'h0, 13'h0000);
        #1;
        chk({o_self_ref, o_dll_en}, 2'b10, "self refresh entry");
        p = pulses;
        u_ctrl.sr_exit();
        #1;
        chk({o_self_ref, o_dll_en}, 2'b01, "self refresh exit");
        chk(pulses, p + 1, "exit loop reset");
    endtask
    task automatic drv(input logic [12:0] a, input logic oe, input logic lv);
        u_ctrl.mrs(2'h1, a);
        #1;
        chk(o_drv_oe, oe, "drive enable");
        chk({o_dq_out, o_dqs_out, o_dqs_n_out}, {{16{lv}}, {2{lv}}, {2{~lv & oe}}}, "drive levels");
    endtask
    task automatic adj(input logic [3:0] c, inout logic [3:0] pu, inout logic [3:0] pd);
        u_ctrl.mrs(2'h1, 13'h0200);
        u_ctrl.burst(c);
        u_ctrl.mrs(2'h1, 13'h0000);
        if (c[1:0] != 2'b11 && c[3:2] != 2'b11) begin
            pu = upd(pu, c[1:0]);
            pd = upd(pd, c[3:2]);
        end
        #1;
        chk({o_pu_step, o_pd_step}, {pu, pd}, "steps");
    endtask
    task automatic t_adjust();
        logic [3:0] pu, pd;
        u_ctrl.mrs(2'h0, 13'h0042);
        u_ctrl.mrs(2'h1, 13'h0380);
        #1;
        chk({o_pu_step, o_pd_step, o_ocd_default}, 9'h111, "default set");
        u_ctrl.mrs(2'h1, 13'h0000);
        pu = 4'h8;
        pd = 4'h8;
        for (int c = 0; c < 16; c++) adj(c[3:0], pu, pd);
        chk(o_ocd_default, 0, "default dropped");
        for (int n = 0; n < 26; n++) adj(n < 9 ? 4'h5 : 4'ha, pu, pd);
        u_ctrl.mrs(2'h1, 13'h0000);
        u_ctrl.mrs(2'h1, 13'h0382);
        #1;
        chk({o_pu_step, o_pd_step, o_ocd_default}, 9'h110, "reduced default");
        u_ctrl.mrs(2'h1, 13'h0002);
        u_ctrl.mrs(2'h1, 13'h0202);
        u_ctrl.burst(4'h5);
        repeat (2) @(posedge i_clk);
        #1;
        chk({o_pu_step, o_pd_step}, 8'h88, "reduced adjust ignored");
        u_ctrl.mrs(2'h1, 13'h0002);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        u_ctrl.sr_exit();
        t_mode();
        t_ext();
        t_selfref();
        drv(13'h0080, 1'b1, 1'b1);
        drv(13'h0000, 1'b0, 1'b0);
        drv(13'h0100, 1'b1, 1'b0);
        drv(13'h0000, 1'b0, 1'b0);
        t_adjust();
        complete_run();
    end
endmodule // ddr2_mode_register_ocd_tb
`default_nettype wire
